// *** hdl/station_pin_pkg.sv ***
package station_pin_pkg;
  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] OFS_BASE_CONFIG = 8'h00;
  localparam logic [7:0] OFS_IRQ_ONE_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ONE_CONTROL = 8'h08;
  localparam logic [7:0] OFS_IRQ_TWO_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_TWO_CONTROL = 8'h10;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h14;
  localparam logic [7:0] OFS_TX_DATA = 8'h18;
  localparam logic [7:0] OFS_RX_DATA = 8'h1c;
  localparam logic [7:0] OFS_LINK_STATUS = 8'h20;
  localparam logic [7:0] OFS_DATA_HI = 8'h24;
  // Base configuration field positions
  localparam int CFG_SA_LSB = 0;
  localparam int CFG_OWN_LSB = 8;
  localparam int CFG_BPS_LSB = 16;
  // Link control field positions
  localparam int CTL_LINK_UP = 0;
  localparam int CTL_EXT_BAUD = 1;
  localparam int CTL_LOC_ERR = 2;
  localparam int CTL_REM_ERR = 3;
  // Interrupt status bits
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_LOC_ERR = 2;
  localparam int IRQ_REM_ERR = 3;
  localparam int IRQ_BITS = 4;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int LED_PULSE_MS = 50;
  localparam int LED_PULSE_CYC = LED_PULSE_MS * CLK_MHZ * 1000;
  localparam int INT_BIT_DIV = 16;
  localparam int EXT_BAUD_DIV = 4;
  localparam int EXT_BAUD_MAX_KHZ = 12500;
  localparam int FRAME_BITS = 10;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP = 3'b100
  } tx_state_t;
endpackage

// *** hdl/station_pin_top.sv ***
`timescale 1ns/1ps
module station_pin_top #(
  parameter int LED_CYCLES = station_pin_pkg::LED_PULSE_CYC,
  parameter int BIT_DIV = station_pin_pkg::INT_BIT_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] data_hi_in,
  output logic [15:0] data_hi_out,
  output logic data_hi_oe_b,
  input wire logic host_rd,
  input wire logic host_wr,
  output logic irq_out_b_one,
  output logic irq_out_b_two,
  output logic irq,
  input wire logic rx_in,
  output logic tx_out,
  output logic line_drive_en,
  input wire logic [5:0] station_addr_strap_b,
  input wire logic [5:0] owned_width_strap_b,
  input wire logic baud_sel_strap_0,
  input wire logic baud_sel_strap_1,
  input wire logic ext_baud_clk,
  output logic link_led_b,
  output logic local_err_led_b,
  output logic remote_err_led_b
);
  import station_pin_pkg::*;

  logic [31:0] base_config_reg;
  logic [31:0] ctrl_reg;
  logic [3:0] irq_one_status, irq_two_status, irq_one_control, irq_two_control;
  logic [15:0] data_hi_reg;
  logic [7:0] tx_data_reg, rx_data_reg;
  logic tx_start;
  logic [3:0] ev;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] rd_val;
  logic rd_hit;

  // Straps sampled every reset cycle; last value before release is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_config_reg <= 32'h0;
      base_config_reg[CFG_SA_LSB +: 6] <= ~station_addr_strap_b;
      base_config_reg[CFG_OWN_LSB +: 6] <= ~owned_width_strap_b;
      base_config_reg[CFG_BPS_LSB +: 2] <= {baud_sel_strap_1, baud_sel_strap_0};
    end
  end

  // Write channel: address and data accepted independently
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign wr_fire = (aw_hold || (s_axi_awvalid && s_axi_awready))
    && (w_hold || (s_axi_wvalid && s_axi_wready));
  wire [7:0] wa = aw_hold ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold ? w_data_reg : s_axi_wdata;
  wire [3:0] ws = w_hold ? w_strb_reg : s_axi_wstrb;
  wire wr_ok = wa == OFS_IRQ_ONE_STATUS || wa == OFS_IRQ_ONE_CONTROL
    || wa == OFS_IRQ_TWO_STATUS || wa == OFS_IRQ_TWO_CONTROL || wa == OFS_LINK_CTRL
    || wa == OFS_TX_DATA || wa == OFS_DATA_HI || wa == OFS_BASE_CONFIG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
        aw_hold <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
        w_hold <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software registers; base config is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      irq_one_control <= MASK_RESET;
      irq_two_control <= MASK_RESET;
      tx_data_reg <= 8'h0;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (wr_fire && ws[0]) begin
        case (wa)
          OFS_IRQ_ONE_CONTROL: irq_one_control <= wd[3:0];
          OFS_IRQ_TWO_CONTROL: irq_two_control <= wd[3:0];
          OFS_LINK_CTRL: ctrl_reg <= wd;
          OFS_TX_DATA: begin
            tx_data_reg <= wd[7:0];
            tx_start <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Host upper lanes: sampled on write, driven while host reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_hi_reg <= 16'h0;
    end else if (host_wr) begin
      data_hi_reg <= data_hi_in;
    end else if (wr_fire && wa == OFS_DATA_HI) begin
      data_hi_reg <= wd[15:0];
    end
  end
  assign data_hi_out = data_hi_reg;
  assign data_hi_oe_b = !host_rd;

  // Sticky status, write one to clear; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_one_status <= 4'h0;
      irq_two_status <= 4'h0;
    end else begin
      irq_one_status <= (irq_one_status
        & ~((wr_fire && wa == OFS_IRQ_ONE_STATUS) ? wd[3:0] : 4'h0)) | ev;
      irq_two_status <= (irq_two_status
        & ~((wr_fire && wa == OFS_IRQ_TWO_STATUS) ? wd[3:0] : 4'h0)) | ev;
    end
  end
  assign irq_out_b_one = !(|(irq_one_status & irq_one_control));
  assign irq_out_b_two = !(|(irq_two_status & irq_two_control));
  assign irq = !irq_out_b_one || !irq_out_b_two;

  // Read channel
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_BASE_CONFIG: rd_val = base_config_reg;
      OFS_IRQ_ONE_STATUS: rd_val = {28'h0, irq_one_status};
      OFS_IRQ_ONE_CONTROL: rd_val = {28'h0, irq_one_control};
      OFS_IRQ_TWO_STATUS: rd_val = {28'h0, irq_two_status};
      OFS_IRQ_TWO_CONTROL: rd_val = {28'h0, irq_two_control};
      OFS_LINK_CTRL: rd_val = ctrl_reg;
      OFS_TX_DATA: rd_val = {24'h0, tx_data_reg};
      OFS_RX_DATA: rd_val = {24'h0, rx_data_reg};
      OFS_LINK_STATUS: rd_val = {29'h0, !local_err_led_b || !remote_err_led_b,
        !link_led_b, line_drive_en};
      OFS_DATA_HI: rd_val = {16'h0, data_hi_reg};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bit tick: internal divider, or every fourth rising edge of the external clock.
  // External clock treated as synchronous input; must not exceed 12.5 MHz.
  logic [15:0] div_cnt;
  logic [1:0] ext_cnt;
  logic ext_d, bit_tick;
  wire ext_rise = ext_baud_clk && !ext_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 16'h0;
      ext_cnt <= 2'h0;
      ext_d <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      ext_d <= ext_baud_clk;
      bit_tick <= 1'b0;
      if (ctrl_reg[CTL_EXT_BAUD]) begin
        if (ext_rise) begin
          ext_cnt <= ext_cnt + 2'd1;
          bit_tick <= ext_cnt == 2'(EXT_BAUD_DIV - 1);
        end
      end else if (div_cnt == 16'(BIT_DIV - 1)) begin
        div_cnt <= 16'h0;
        bit_tick <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'd1;
      end
    end
  end

  // Transmitter: start bit, 8 data LSB first, stop bit
  tx_state_t tx_state;
  logic [8:0] tx_shift;
  logic [3:0] tx_cnt;
  logic tx_armed;
  // Frame waits for a bit tick, else the free-running divider clips the start bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= 9'h1ff;
      tx_cnt <= 4'h0;
      tx_armed <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: if (tx_start) begin
          tx_shift <= {tx_data_reg, 1'b0};
          tx_cnt <= 4'h0;
          tx_armed <= 1'b1;
        end else if (tx_armed && bit_tick) begin
          tx_armed <= 1'b0;
          tx_state <= TX_SHIFT;
        end
        TX_SHIFT: if (bit_tick) begin
          tx_shift <= {1'b1, tx_shift[8:1]};
          tx_cnt <= tx_cnt + 4'd1;
          if (tx_cnt == 4'(FRAME_BITS - 1)) tx_state <= TX_STOP;
        end
        TX_STOP: tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  assign tx_out = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;
  assign line_drive_en = tx_state == TX_SHIFT;

  // Receiver samples rx_in on bit ticks after a low start bit
  logic rx_busy;
  logic [3:0] rx_cnt;
  logic [7:0] rx_shift;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy <= 1'b0;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h0;
      rx_data_reg <= 8'h0;
    end else if (bit_tick) begin
      if (!rx_busy) begin
        rx_busy <= !rx_in;
        rx_cnt <= 4'h0;
      end else if (rx_cnt == 4'd8) begin
        rx_busy <= 1'b0;
        rx_data_reg <= rx_shift;
      end else begin
        rx_shift <= {rx_in, rx_shift[7:1]};
        rx_cnt <= rx_cnt + 4'd1;
      end
    end
  end
  wire rx_done = bit_tick && rx_busy && rx_cnt == 4'd8;

  // Error events are rising edges of the control request bits
  logic loc_d, rem_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_d <= 1'b0;
      rem_d <= 1'b0;
    end else begin
      loc_d <= ctrl_reg[CTL_LOC_ERR];
      rem_d <= ctrl_reg[CTL_REM_ERR];
    end
  end
  wire local_error_event = ctrl_reg[CTL_LOC_ERR] && !loc_d;
  wire remote_error_event = ctrl_reg[CTL_REM_ERR] && !rem_d;
  wire tx_done = tx_state == TX_STOP;
  assign ev = {remote_error_event, local_error_event, rx_done, tx_done};

  logic [31:0] loc_cnt, rem_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_cnt <= 32'h0;
      rem_cnt <= 32'h0;
    end else begin
      if (local_error_event) loc_cnt <= 32'(LED_CYCLES);
      else if (loc_cnt != 32'h0) loc_cnt <= loc_cnt - 32'd1;
      if (remote_error_event) rem_cnt <= 32'(LED_CYCLES);
      else if (rem_cnt != 32'h0) rem_cnt <= rem_cnt - 32'd1;
    end
  end
  assign local_err_led_b = loc_cnt == 32'h0;
  assign remote_err_led_b = rem_cnt == 32'h0;
  assign link_led_b = !ctrl_reg[CTL_LINK_UP];

  a_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> $stable(base_config_reg)) else $error("strap changed");
  a_drive_en_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(line_drive_en) |-> $past(tx_armed && bit_tick)) else $error("drive without start");
  a_irq_one_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_out_b_one == !(|(irq_one_status & irq_one_control))) else $error("irq1");
  a_irq_two_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (|(irq_two_status & irq_two_control)) |-> !irq_out_b_two) else $error("irq2");
  a_local_led_on: assert property (@(posedge aclk) disable iff (!aresetn)
    local_error_event |=> !local_err_led_b [*2]) else $error("local led");
  a_remote_led_on: assert property (@(posedge aclk) disable iff (!aresetn)
    remote_error_event |=> !remote_err_led_b [*2]) else $error("remote led");
  a_link_led_map: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ctrl_reg[CTL_LINK_UP]) |-> !link_led_b) else $error("link led");
  a_tx_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    !line_drive_en |-> tx_out) else $error("tx not idle");
endmodule

// *** dv/line_xcvr_model.sv ***
`timescale 1ns/1ps
module line_xcvr_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic aclk,
  input wire logic tx_out,
  input wire logic line_drive_en,
  output logic rx_in
);
  logic q[$];
  int frames = 0;
  int last_len = 0;
  logic [9:0] last_bits = '0;
  // Receiver output idles high while the line is quiet
  initial rx_in = 1'b1;
  // Bit period comes from the frame length, so either baud source decodes
  always @(posedge aclk) begin
    if (line_drive_en) begin
      q.push_back(tx_out);
    end else if (q.size() > 0) begin
      last_len = q.size();
      for (int k = 0; k < 10; k++) last_bits[k] = q[k * last_len / 10 + last_len / 20];
      frames++;
      q.delete();
    end
  end
  task automatic send(input logic [7:0] d);
    for (int k = 0; k < 10; k++) begin
      rx_in <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : d[k - 1];
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask
endmodule

// *** dv/station_pin_interface_bench.sv ***
`timescale 1ns/1ps
module station_pin_interface_bench;
  import station_pin_pkg::*;
  localparam int LEDC = 20;
  localparam int BITC = 4;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic host_rd, host_wr, data_hi_oe_b, irq_out_b_one, irq_out_b_two, irq, rx_in, tx_out;
  logic line_drive_en, baud_sel_strap_0, baud_sel_strap_1, ext_baud_clk, link_led_b;
  logic local_err_led_b, remote_err_led_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] data_hi_in, data_hi_out;
  logic [5:0] station_addr_strap_b, owned_width_strap_b;
  logic [13:0] straps;
  logic [6:0] obs;
  int error_cnt = 0, total_checks = 0, cyc = 0, n;
  int run[2] = '{0, 0};
  int last_run[2] = '{0, 0};
  assign {station_addr_strap_b, owned_width_strap_b} = straps[13:2];
  assign {baud_sel_strap_1, baud_sel_strap_0} = straps[1:0];
  assign obs = {data_hi_oe_b, link_led_b, remote_err_led_b, local_err_led_b, irq,
    irq_out_b_two, irq_out_b_one};
  station_pin_top #(.LED_CYCLES(LEDC), .BIT_DIV(BITC)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_hi_in, .data_hi_out,
    .data_hi_oe_b, .host_rd, .host_wr, .irq_out_b_one, .irq_out_b_two, .irq, .rx_in, .tx_out,
    .line_drive_en, .station_addr_strap_b, .owned_width_strap_b, .baud_sel_strap_0,
    .baud_sel_strap_1, .ext_baud_clk, .link_led_b, .local_err_led_b, .remote_err_led_b);
  line_xcvr_model #(.BIT_CYC(BITC)) xcvr (.aclk, .tx_out, .line_drive_en, .rx_in);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // 12.5 MHz, the highest rate allowed, and off the main clock's rising edges
  always #40 ext_baud_clk = ~ext_baud_clk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // Lengths of LED low pulses, measured beside the sequence
  always @(posedge aclk) begin
    for (int j = 0; j < 2; j++) begin
      run[j] <= obs[3 + j] === 1'b0 ? run[j] + 1 : 0;
      if (obs[3 + j] !== 1'b0 && run[j] > 0) last_run[j] <= run[j];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Response ready stays high for the whole run, so no release can collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic settle(input int k, input logic val);
    n = 0;
    while (obs[k] !== val && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, obs[k]}, {31'h0, val});
  endtask
  task automatic trig(input int i);
    wr(OFS_LINK_CTRL, 32'h0);
    wr(OFS_LINK_CTRL, 32'h1 << (CTL_LOC_ERR + i));
  endtask
  function automatic logic [31:0] cfg_exp(input logic [13:0] s);
    return {14'h0, s[1:0], 2'h0, ~s[7:2], 2'h0, ~s[13:8]};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, host_rd, host_wr, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, data_hi_in, ext_baud_clk} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    void'($urandom(32'hd49d));
    v = $urandom;
    straps = v[13:0];
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    straps <= ~v[13:0];
    rdr(OFS_BASE_CONFIG);
    chk(rd, cfg_exp(v[13:0]));
    rdr(8'h80);
    chk({30'h0, resp}, 32'h2);
    $display("straps and map done");
    wr(OFS_LINK_CTRL, 32'h1 << CTL_LINK_UP);
    settle(5, 1'b0);
    rdr(OFS_LINK_STATUS);
    chk(rd, 32'h2);
    wr(OFS_LINK_CTRL, 32'h0);
    settle(5, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_IRQ_ONE_STATUS, 32'hf);
      wr(OFS_IRQ_TWO_STATUS, 32'hf);
      wr(OFS_IRQ_ONE_CONTROL, i == 0 ? 32'hf : 32'h0);
      wr(OFS_IRQ_TWO_CONTROL, i == 1 ? 32'hf : 32'h0);
      trig(i);
      settle(3 + i, 1'b0);
      settle(i, 1'b0);
      settle(1 - i, 1'b1);
      settle(2, 1'b1);
      settle(3 + i, 1'b1);
      @(posedge aclk);
      chk(last_run[i], LEDC);
      wr(i == 0 ? OFS_IRQ_ONE_STATUS : OFS_IRQ_TWO_STATUS, 32'h1 << (IRQ_LOC_ERR + i));
      settle(i, 1'b1);
      trig(i);
      repeat (4) @(posedge aclk);
      trig(i);
      settle(3 + i, 1'b1);
      @(posedge aclk);
      chk({31'h0, last_run[i] > LEDC}, 32'h1);
    end
    $display("leds and interrupts done");
    for (int k = 0; k < 4; k++) begin
      b = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
      wr(OFS_LINK_CTRL, 32'(k == 3) << CTL_EXT_BAUD);
      n = xcvr.frames;
      wr(OFS_TX_DATA, {24'h0, b});
      while (xcvr.frames == n) @(posedge aclk);
      chk({22'h0, xcvr.last_bits}, {22'h0, 1'b1, b, 1'b0});
      chk(xcvr.last_len, 10 * (k == 3 ? 40 : BITC));
      if (k < 3) begin
        xcvr.send(~b);
        rdr(OFS_RX_DATA);
        chk(rd & 32'hff, {24'h0, ~b});
      end
    end
    rdr(OFS_IRQ_ONE_STATUS);
    chk(rd & 32'h3, 32'h3);
    $display("serial done");
    v = $urandom;
    data_hi_in <= v[15:0];
    host_wr <= 1'b1;
    @(posedge aclk);
    host_wr <= 1'b0;
    data_hi_in <= ~v[15:0];
    host_rd <= 1'b1;
    settle(6, 1'b0);
    @(posedge aclk);
    chk({16'h0, data_hi_out}, {16'h0, v[15:0]});
    host_rd <= 1'b0;
    settle(6, 1'b1);
    wr(OFS_DATA_HI, {16'h0, ~v[15:0]});
    rdr(OFS_DATA_HI);
    chk(rd, {16'h0, ~v[15:0]});
    chk({16'h0, data_hi_out}, {16'h0, ~v[15:0]});
    $display("upper lanes done");
    conclude();
  end
endmodule
